// ### logic/cqt_transfer.sv
// write and read controllers moving words from a source memory through an
// external queue into an internal sink memory, plus an apb status slave
// assumes the queue and source memory run on clk and their flags are
// already synchronous to it; the queue's own crossing is not in here
// Function
// - reset: write side idle, push low, index 00
// - leave write idle when full low
// - write advance: push low, index plus one
// - read idle holds while queue empty
// - read idle after reset: index ff, wraps to 00
// - read idle to advance when not empty
// - read advance: pop high, index plus one
// - read advance always goes to write
// - read write: store and read back word
// - read write: count one more word
// - alternate advance and write while not empty
// - write advance with full goes wait
// - write wait holds source index
// - wait while full, then write
// - write state pushes, advances unless ff
// - write at ff: final push, then done
// - done: no further pushes
// - empty ends transfer, last at ff, 256
module cqt_transfer
    import cqt_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic      [DATA_W-1:0]  prdata,
    output logic                    pready,
    output logic                    pslverr,
    // queue write side
    input  wire logic               q_wr_full,
    output logic                    q_push,
    output logic      [INDEX_W-1:0] src_index,
    // queue read side
    input  wire logic               q_rd_empty,
    input  wire logic [DATA_W-1:0]  q_rd_data,
    input  wire logic [ECC_W-1:0]   q_ecc_status,
    output logic                    q_pop,
    // sink memory view
    output logic      [INDEX_W-1:0] sink_index,
    output logic                    sink_wr_en,
    output logic                    sink_rd_en,
    output logic      [DATA_W-1:0]  readback_q,
    output logic      [COUNT_W-1:0] word_count,
    output logic      [ECC_W-1:0]   ecc_last,
    output logic                    transfer_done
);

    // index step with natural wrap, used by both controllers
    function automatic logic [INDEX_W-1:0] index_inc(
        input logic [INDEX_W-1:0] idx
    );
        index_inc = idx + INDEX_STEP;
    endfunction : index_inc

    // true when an index points at the last word
    function automatic logic index_is_last(input logic [INDEX_W-1:0] idx);
        index_is_last = (idx == INDEX_LAST);
    endfunction : index_is_last

    // ------------------------------------------------------------------
    // write controller
    // ------------------------------------------------------------------
    cqt_wr_state_t     wr_state_reg;   // current write state
    cqt_wr_state_t     wr_state_next;  // next write state
    logic [INDEX_W-1:0] src_index_reg; // source memory index

    // next state for the write side
    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            WR_IDLE: begin
                // start only once the queue has room
                if (!q_wr_full) begin
                    wr_state_next = WR_WRITE;
                end
            end
            WR_WRITE: begin
                // last word goes straight to done
                if (index_is_last(src_index_reg)) begin
                    wr_state_next = WR_DONE;
                end else begin
                    wr_state_next = WR_ADVANCE;
                end
            end
            WR_ADVANCE: begin
                // a full queue parks the pending word
                if (q_wr_full) begin
                    wr_state_next = WR_WAIT;
                end else begin
                    wr_state_next = WR_WRITE;
                end
            end
            WR_WAIT: begin
                // full may clear many cycles after a pop; just keep waiting
                if (!q_wr_full) begin
                    wr_state_next = WR_WRITE;
                end
            end
            WR_DONE: begin
                wr_state_next = WR_DONE;
            end
            default: begin
                wr_state_next = WR_IDLE;
            end
        endcase
    end

    // write state register
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_state_reg <= WR_IDLE;
        end else begin
            wr_state_reg <= wr_state_next;
        end
    end

    // source index: moves only in the advance state, held elsewhere
    always_ff @(posedge clk) begin
        if (srst) begin
            src_index_reg <= INDEX_FIRST;
        end else if (wr_state_reg == WR_ADVANCE) begin
            src_index_reg <= index_inc(src_index_reg);
        end
    end

    // push only in the write state; low in idle, advance, wait and done
    assign q_push    = (wr_state_reg == WR_WRITE);
    assign src_index = src_index_reg;

    // ------------------------------------------------------------------
    // read controller
    // ------------------------------------------------------------------
    cqt_rd_state_t      rd_state_reg;    // current read state
    cqt_rd_state_t      rd_state_next;   // next read state
    logic [INDEX_W-1:0] sink_index_reg;  // sink memory index
    logic [COUNT_W-1:0] word_count_reg;  // words taken from the queue
    logic [ECC_W-1:0]   ecc_last_reg;    // status of the last stored word

    // next state for the read side
    always_comb begin
        rd_state_next = rd_state_reg;
        case (rd_state_reg)
            RD_IDLE: begin
                // nothing to take while the queue is empty
                if (!q_rd_empty) begin
                    rd_state_next = RD_ADVANCE;
                end else begin
                    rd_state_next = RD_IDLE;
                end
            end
            RD_ADVANCE: begin
                rd_state_next = RD_WRITE;
            end
            RD_WRITE: begin
                // keep streaming until the queue runs dry
                if (q_rd_empty) begin
                    rd_state_next = RD_IDLE;
                end else begin
                    rd_state_next = RD_ADVANCE;
                end
            end
            default: begin
                rd_state_next = RD_IDLE;
            end
        endcase
    end

    // read state register
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_state_reg <= RD_IDLE;
        end else begin
            rd_state_reg <= rd_state_next;
        end
    end

    // sink index sits at ff so the first advance lands on 00; it is not
    // reloaded on a later return to idle, which would overwrite stored words
    always_ff @(posedge clk) begin
        if (srst) begin
            sink_index_reg <= INDEX_LAST;
        end else if (rd_state_reg == RD_ADVANCE) begin
            sink_index_reg <= index_inc(sink_index_reg);
        end
    end

    // word counter, one per stored word
    always_ff @(posedge clk) begin
        if (srst) begin
            word_count_reg <= COUNT_ZERO;
        end else if (rd_state_reg == RD_WRITE) begin
            word_count_reg <= word_count_reg + COUNT_STEP;
        end
    end

    // the popped word and its status are valid in the write state
    always_ff @(posedge clk) begin
        if (srst) begin
            ecc_last_reg <= ECC_NONE;
        end else if (rd_state_reg == RD_WRITE) begin
            ecc_last_reg <= q_ecc_status;
        end
    end

    // pop and sink strobes straight from the state
    assign q_pop      = (rd_state_reg == RD_ADVANCE);
    assign sink_wr_en = (rd_state_reg == RD_WRITE);
    assign sink_rd_en = (rd_state_reg == RD_WRITE);
    assign sink_index = sink_index_reg;
    assign word_count = word_count_reg;
    assign ecc_last   = ecc_last_reg;
    assign transfer_done = (wr_state_reg == WR_DONE);

    // sink memory; read data is registered inside
    cqt_sink_mem u_sink_mem (
        .clk   (clk),
        .wr_en (sink_wr_en),
        .rd_en (sink_rd_en),
        .index (sink_index_reg),
        .wdata (q_rd_data),
        .rdata (readback_q)
    );

    // ------------------------------------------------------------------
    // error counters and apb slave
    // ------------------------------------------------------------------
    logic [ERRC_W-1:0] fixed_cnt_reg;  // corrected words seen
    logic [ERRC_W-1:0] fatal_cnt_reg;  // uncorrectable words seen
    logic              cnt_clear;      // software clears both counters
    logic              ev_fixed;       // corrected word stored this cycle
    logic              ev_fatal;       // uncorrectable word stored
    logic              setup_phase;    // apb setup cycle
    logic              addr_known;     // address hits a register

    assign setup_phase = psel && !penable;
    assign cnt_clear   = psel && penable && pwrite
                         && (paddr == REG_CTRL) && pwdata[CTRL_CLR_BIT];
    assign ev_fixed    = sink_wr_en && (q_ecc_status == ECC_FIXED);
    assign ev_fatal    = sink_wr_en && (q_ecc_status == ECC_FATAL);

    // a count arriving with the clear is kept: set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            fixed_cnt_reg <= ERRC_ZERO;
        end else if (cnt_clear) begin
            fixed_cnt_reg <= ev_fixed ? ERRC_STEP : ERRC_ZERO;
        end else if (ev_fixed) begin
            fixed_cnt_reg <= fixed_cnt_reg + ERRC_STEP;
        end
    end

    // same policy for the uncorrectable counter
    always_ff @(posedge clk) begin
        if (srst) begin
            fatal_cnt_reg <= ERRC_ZERO;
        end else if (cnt_clear) begin
            fatal_cnt_reg <= ev_fatal ? ERRC_STEP : ERRC_ZERO;
        end else if (ev_fatal) begin
            fatal_cnt_reg <= fatal_cnt_reg + ERRC_STEP;
        end
    end

    // address decode
    always_comb begin
        case (paddr)
            REG_STATUS, REG_WORDS, REG_FIXED,
            REG_FATAL, REG_CTRL: addr_known = 1'b1;
            default:             addr_known = 1'b0;
        endcase
    end

    // read data and error are captured in setup so the access phase can
    // finish with no wait state
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata  <= RDATA_ZERO;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= !addr_known;
            prdata  <= RDATA_ZERO;
            if (!pwrite) begin
                case (paddr)
                    REG_STATUS: prdata <= {24'h00_0000, transfer_done,
                                           ecc_last_reg, rd_state_reg,
                                           wr_state_reg};
                    REG_WORDS:  prdata <= {23'h00_0000, word_count_reg};
                    REG_FIXED:  prdata <= {16'h0000, fixed_cnt_reg};
                    REG_FATAL:  prdata <= {16'h0000, fatal_cnt_reg};
                    default:    prdata <= RDATA_ZERO;
                endcase
            end
        end
    end

    assign pready = 1'b1; // every access completes in its first cycle

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_wr_adv_full;
        (wr_state_reg == WR_ADVANCE) && q_wr_full;
    endsequence

    sequence s_rd_adv_then_write;
        q_pop ##1 (rd_state_reg == RD_WRITE) && sink_wr_en && sink_rd_en;
    endsequence

    a_wr_reset_idle: assert property (@(posedge clk)
        srst |=> (wr_state_reg == WR_IDLE) && !q_push
                 && (src_index == INDEX_FIRST))
        else $error("write side not idle after reset");

    a_wr_idle_start: assert property (@(posedge clk) disable iff (srst)
        (wr_state_reg == WR_IDLE) && !q_wr_full |=> q_push)
        else $error("write side did not start");

    a_wr_index_step: assert property (@(posedge clk) disable iff (srst)
        (wr_state_reg == WR_ADVANCE) |-> !q_push
            ##1 src_index == index_inc($past(src_index)))
        else $error("source index did not step");

    a_rd_idle_hold: assert property (@(posedge clk) disable iff (srst)
        (rd_state_reg == RD_IDLE) && q_rd_empty |=> !q_pop && !sink_wr_en)
        else $error("read side left idle while empty");

    a_rd_step_write: assert property (@(posedge clk)
        disable iff (srst)
        (rd_state_reg == RD_IDLE) && !q_rd_empty |=> s_rd_adv_then_write)
        else $error("read advance and write out of order");

    a_rd_index_wrap: assert property (@(posedge clk) disable iff (srst)
        q_pop |=> sink_index == index_inc($past(sink_index)))
        else $error("sink index did not step");

    a_rd_word_count: assert property (@(posedge clk) disable iff (srst)
        sink_wr_en |=> word_count == $past(word_count) + COUNT_STEP)
        else $error("word count did not step");

    a_rd_stream_on: assert property (@(posedge clk) disable iff (srst)
        sink_wr_en && !q_rd_empty |=> q_pop)
        else $error("read side stalled with data waiting");

    a_wr_full_wait: assert property (@(posedge clk)
        disable iff (srst)
        s_wr_adv_full ##1 q_wr_full[*2] |-> !q_push
            && (wr_state_reg == WR_WAIT) && $stable(src_index))
        else $error("write side did not hold while full");

    a_wr_last_done: assert property (@(posedge clk)
        disable iff (srst)
        q_push && (src_index == INDEX_LAST) |=> !q_push[*3])
        else $error("push after the last word");

endmodule : cqt_transfer

// ### logic/cqt_pkg.sv
// shared constants and types for the queue transfer controllers
// assumes one clock for both controllers and a 32-bit apb master
package cqt_pkg;

    // data path and index widths
    localparam int unsigned DATA_W  = 32;       // word width through the queue
    localparam int unsigned INDEX_W = 8;        // memory index width
    localparam int unsigned COUNT_W = 9;        // word counter, reaches 256
    localparam int unsigned ECC_W   = 2;        // correction status width
    localparam int unsigned ERRC_W  = 16;       // error counter width
    localparam int unsigned ADDR_W  = 8;        // apb address width

    // index values
    localparam logic [INDEX_W-1:0] INDEX_FIRST = 8'h00; // source start
    localparam logic [INDEX_W-1:0] INDEX_LAST  = 8'hff; // last word, sink idle
    localparam logic [INDEX_W-1:0] INDEX_STEP  = 8'h01; // one word per step

    // counter values
    localparam logic [COUNT_W-1:0] COUNT_ZERO  = 9'h000;
    localparam logic [COUNT_W-1:0] COUNT_STEP  = 9'h001;
    localparam logic [COUNT_W-1:0] COUNT_TOTAL = 9'h100; // 256 words
    localparam logic [ERRC_W-1:0]  ERRC_ZERO   = 16'h0000;
    localparam logic [ERRC_W-1:0]  ERRC_STEP   = 16'h0001;

    // correction status codes reported by the queue
    localparam logic [ECC_W-1:0] ECC_NONE    = 2'h0; // no error
    localparam logic [ECC_W-1:0] ECC_FIXED   = 2'h2; // single bit, corrected
    localparam logic [ECC_W-1:0] ECC_FATAL   = 2'h3; // uncorrectable

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h00; // ro state snapshot
    localparam logic [ADDR_W-1:0] REG_WORDS   = 8'h04; // ro words moved
    localparam logic [ADDR_W-1:0] REG_FIXED   = 8'h08; // ro corrected count
    localparam logic [ADDR_W-1:0] REG_FATAL   = 8'h0c; // ro uncorrectable count
    localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h10; // wo counter clear

    // field positions in the control register
    localparam int unsigned CTRL_CLR_BIT = 0;   // clears error counters
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // write controller states
    typedef enum logic [2:0] {
        WR_IDLE    = 3'b000,
        WR_WRITE   = 3'b001,
        WR_ADVANCE = 3'b010,
        WR_WAIT    = 3'b011,
        WR_DONE    = 3'b100
    } cqt_wr_state_t;

    // read controller states
    typedef enum logic [1:0] {
        RD_IDLE    = 2'b00,
        RD_ADVANCE = 2'b01,
        RD_WRITE   = 2'b10
    } cqt_rd_state_t;

endpackage : cqt_pkg

// ### logic/cqt_sink_mem.sv
// sink memory: 256 words, one write port and one registered read port
// assumes a single clock; read and write to the same index in one cycle
// return the word being written (write-first)
module cqt_sink_mem
    import cqt_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    input  wire logic [INDEX_W-1:0] index,
    input  wire logic [DATA_W-1:0]  wdata,
    output logic      [DATA_W-1:0]  rdata
);

    // storage array, no reset so it maps onto block memory
    logic [DATA_W-1:0] mem_reg [0:(1<<INDEX_W)-1];

    // write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[index] <= wdata;
        end
    end

    // registered read port, write-first so the stored word shows next edge
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rdata <= wr_en ? wdata : mem_reg[index];
        end
    end

endmodule : cqt_sink_mem

// ### tb/cqt_queue_model.sv
// behavioural queue with source memory and correction status
// assumes the controller shares clk and samples flags on rising edges
module cqt_queue_model
    import cqt_pkg::*;
#(
    parameter int DEPTH = 4                     // small so full is reached
)
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               push,
    input  wire logic [INDEX_W-1:0] src_index,
    output logic                    full,
    input  wire logic               pop,
    output logic                    empty,
    output logic      [DATA_W-1:0]  rd_data,
    output logic      [ECC_W-1:0]   ecc,
    input  wire logic               hold_rd,    // read side stall
    input  wire logic [ECC_W-1:0]   ecc_mode    // status for next pop
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] mem [DEPTH];             // queue storage
    int                wp, rp, cnt;             // pointers and fill
    logic [2:0]        late;                    // full release delay

    // full clears late after a pop, as a crossing would
    assign full  = (cnt == DEPTH) | (|late);
    assign empty = (cnt == 0) | hold_rd;

    // storage, registered read and status
    always_ff @(posedge clk) begin
        if (srst) begin
            wp      <= 0;
            rp      <= 0;
            cnt     <= 0;
            late    <= 3'h0;
            rd_data <= 32'h0000_0000;
            ecc     <= 2'h0;
        end else begin
            late <= {late[1:0], cnt == DEPTH};
            if (push && cnt < DEPTH) begin
                // source word is built from the index it came from
                mem[wp] <= {~src_index, src_index, 8'ha5, src_index};
                wp      <= (wp + 1) % DEPTH;
            end
            if (pop && cnt > 0) begin
                rd_data <= mem[rp];
                ecc     <= ecc_mode;
                rp      <= (rp + 1) % DEPTH;
            end else begin
                // no hold: stale data would hide a late store
                rd_data <= ~rd_data;
                ecc     <= ~ecc;
            end
            cnt <= cnt + int'(push && cnt < DEPTH) - int'(pop && cnt > 0);
        end
    end
endmodule : cqt_queue_model

// ### tb/tb_cqt_transfer.sv
// self-checking bench for the transfer controllers
// assumes the queue model above stands on the queue ports
module tb_cqt_transfer;
    import cqt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0]  paddr;
    logic [DATA_W-1:0]  pwdata, prdata, q_rd_data, readback_q;
    logic               q_wr_full, q_push, q_rd_empty, q_pop, transfer_done;
    logic               sink_wr_en, sink_rd_en, hold_rd;
    logic [INDEX_W-1:0] src_index, sink_index;
    logic [ECC_W-1:0]   q_ecc_status, ecc_last, pop_ecc, rb_ecc;
    logic [ECC_W-1:0]   ecc_mode = 2'h0;    // status handed to the next pop
    logic [COUNT_W-1:0] word_count;
    int num_errors, n_compared, exp_src, exp_sink, n_push, n_store, n_pop;
    int exp_fixed, exp_fatal, rb_idx;
    bit rb_pend;
    logic [ECC_W-1:0]   codes [4] = '{2'h0, 2'h2, 2'h3, 2'h0};

    cqt_transfer dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .q_wr_full(q_wr_full),
        .q_push(q_push), .src_index(src_index), .q_rd_empty(q_rd_empty),
        .q_rd_data(q_rd_data), .q_ecc_status(q_ecc_status), .q_pop(q_pop),
        .sink_index(sink_index), .sink_wr_en(sink_wr_en),
        .sink_rd_en(sink_rd_en), .readback_q(readback_q),
        .word_count(word_count), .ecc_last(ecc_last),
        .transfer_done(transfer_done));

    cqt_queue_model #(.DEPTH(4)) queue (.clk(clk), .srst(srst),
        .push(q_push), .src_index(src_index), .full(q_wr_full), .pop(q_pop),
        .empty(q_rd_empty), .rd_data(q_rd_data), .ecc(q_ecc_status),
        .hold_rd(hold_rd), .ecc_mode(ecc_mode));

    // expected source word, worked out independently of the model
    function automatic logic [DATA_W-1:0] src_word(input int i);
        logic [7:0] b;
        b = i[7:0];
        return {~b, b, 8'ha5, b};
    endfunction : src_word

    // compare and count
    task automatic chk(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic close_out;
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // one apb transfer; waits for pready without assuming its latency
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // watchdog: whole run is well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end

    // monitor: push order, stores, readback, counts and status codes
    always @(posedge clk) begin
        if (!srst) begin
            if (q_push) begin
                chk(src_index, exp_src[7:0]);
                if (n_push >= 256) chk(1, 0);
                exp_src++;
                n_push++;
            end
            if (rb_pend) begin
                chk(readback_q, src_word(rb_idx));
                chk(word_count, n_store);
                chk(ecc_last, rb_ecc);
            end
            rb_pend = 0;
            if (sink_wr_en) begin
                chk(sink_index, exp_sink[7:0]);
                chk(sink_rd_en, 1);
                rb_pend = 1;
                rb_idx  = exp_sink;
                rb_ecc  = pop_ecc;
                exp_sink++;
                n_store++;
            end
            if (q_pop) begin
                pop_ecc = ecc_mode;
                if (ecc_mode == ECC_FIXED) exp_fixed++;
                if (ecc_mode == ECC_FATAL) exp_fatal++;
                n_pop++;
                ecc_mode <= codes[n_pop % 4];
            end
        end
    end

    // reset holds both controllers idle, then writing starts at once
    task automatic t_reset;
        int k;
        repeat (2) @(posedge clk);
        chk(q_push, 0);
        chk(src_index, INDEX_FIRST);
        chk({q_pop, sink_wr_en, sink_rd_en}, 0);
        chk(word_count, COUNT_ZERO);
        chk(sink_index, INDEX_LAST);
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (q_push !== 1'b1 && k < 5);
        chk(k <= 2, 1);
    endtask : t_reset

    // read side stalled: queue fills, writer parks in wait
    task automatic t_full_wait;
        logic [DATA_W-1:0] rd;
        logic err;
        repeat (30) @(posedge clk);
        chk(src_index, 8'h04);
        chk(q_push, 0);
        chk(q_pop, 0);
        chk(sink_index, INDEX_LAST);
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        chk(rd[4:0], 5'h03);
        chk(src_index, 8'h04);
    endtask : t_full_wait

    // read side runs: whole transfer drains into the sink
    task automatic t_drain;
        int k;
        hold_rd <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(transfer_done === 1'b1 && word_count === COUNT_TOTAL)
                   && k < 3000);
        repeat (4) @(posedge clk);
        chk(word_count, COUNT_TOTAL);
        chk(transfer_done, 1);
        chk(q_pop, 0);
        chk(readback_q, src_word(255));
        chk(n_push, 256);
        chk(n_store, 256);
    endtask : t_drain

    // status registers, unmapped access and counter clear
    task automatic t_regs;
        logic [DATA_W-1:0] rd;
        logic err;
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        chk(rd[7], 1);
        chk(rd[2:0], 3'h4);
        apb(1'b0, REG_WORDS, 32'h0, rd, err);
        chk(rd, 32'h0000_0100);
        apb(1'b0, REG_FIXED, 32'h0, rd, err);
        chk(rd, exp_fixed);
        apb(1'b0, REG_FATAL, 32'h0, rd, err);
        chk(rd, exp_fatal);
        apb(1'b0, 8'h20, 32'h0, rd, err);
        chk(err, 1);                // unmapped address flags an error
        chk(rd, 32'h0);
        apb(1'b1, REG_CTRL, 32'h0000_0001, rd, err);
        apb(1'b0, REG_FIXED, 32'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, REG_FATAL, 32'h0, rd, err);
        chk(rd, 32'h0);
    endtask : t_regs

    // main sequence
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hold_rd = 1'b1;
        t_reset();
        t_full_wait();
        t_drain();
        t_regs();
        close_out();
    end
endmodule : tb_cqt_transfer
